// ---- hw/hrp_pkg.sv ----
// hrp_pkg: constants, state types and the per-end state records of the host register port.
// Assumes one clock (core_clk) shared by both ends and an active-low asynchronous reset.
//
// Contract
// R1 - device synchronises select and strobes before use; split-style ready is pulled low from the raw pins
// R2 - select may stay low; strobes delimit accesses
// R3 - missed strobe assertion starts at later edge
// R4 - missed strobe release delays access end
// R5 - host presents address; device decodes it
// R6 - data-strobe read: data and ack together
// R7 - data-strobe write: capture data, then ack
// R8 - split read: ready low, then data, ready high
// R9 - split write: ready low, high once data taken
// R10 - strobe high releases data bus and ack
// R11 - split write strobe high releases ready
// R12 - host holds address, select, rw until strobe high
// R13 - host holds write data until strobe high
// R14 - pass-through read drives peripheral select, strobe
// R15 - pass-through read captures byte on falling edge
// R16 - pass-through write drives select, enable, data
// R17 - reset synchronised, held five clocks minimum
// R18 - static input selects strobe style
// R19 - peripheral data bus released unless writing
package hrp_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int SYNC_DEPTH = 3;
	localparam int NUM_SYNC = 4;

	// slots of the synchronised host inputs
	localparam int SYN_SEL = 0;
	localparam int SYN_PASS = 1;
	localparam int SYN_DS = 2;
	localparam int SYN_RW = 3;

	localparam logic [2:0] RST_MIN_CLKS = 3'h5;
	localparam logic [2:0] HOST_GAP_CLKS = 3'h4;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;

	typedef enum logic {
		STYLE_STROBE_RW,
		STYLE_SPLIT
	} hrp_style_t;

	typedef enum logic [2:0] {
		DEV_IDLE,
		DEV_REG_WR,
		DEV_REG_RD,
		DEV_PT_RD,
		DEV_PT_WR,
		DEV_ACK
	} hrp_dev_state_t;

	typedef enum logic [2:0] {
		HST_RST,
		HST_IDLE,
		HST_SETUP,
		HST_STROBE,
		HST_HOLD
	} hrp_hst_state_t;

	typedef struct packed {
		logic [NUM_SYNC-1:0][SYNC_DEPTH-1:0] sync;
		logic [NUM_SYNC-1:0] filt;
		hrp_dev_state_t st;
		logic wr;
		logic pt;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
	} hrp_dev_reg_t;

	typedef struct packed {
		hrp_hst_state_t st;
		logic [2:0] cnt;
		logic wr;
		logic pt;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic rsp;
	} hrp_hst_reg_t;

endpackage : hrp_pkg

// ---- hw/hrp_bus_if.sv ----
// hrp_bus_if: the host-facing pins between the host end and the device end.
// Assumes both ends share core_clk; wire levels are resolved here from the enables.
`timescale 1ns/100ps
`default_nettype none

interface hrp_bus_if (
	input wire logic core_clk
);
	logic host_select_n;
	logic periph_pass_select_n;
	logic data_or_read_strobe_n;
	logic rw_or_write_strobe_n;
	logic [hrp_pkg::ADDR_W-1:0] addr;
	logic [hrp_pkg::DATA_W-1:0] host_data_out;
	logic host_data_oe;
	logic [hrp_pkg::DATA_W-1:0] dev_data_out;
	logic dev_data_oe;
	logic transfer_ack_or_wait;
	logic ack_oe;
	logic [hrp_pkg::DATA_W-1:0] data_bus;
	logic ack_level;

	// pulled-up wires: an undriven line reads high
	assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : hrp_pkg::BUS_IDLE);
	assign ack_level = ack_oe ? transfer_ack_or_wait : 1'b1;

	modport host_end (
		input core_clk, data_bus, ack_level,
		output host_select_n, periph_pass_select_n, data_or_read_strobe_n,
		output rw_or_write_strobe_n, addr, host_data_out, host_data_oe
	);

	modport dev_end (
		input core_clk, host_select_n, periph_pass_select_n, data_or_read_strobe_n,
		input rw_or_write_strobe_n, addr, data_bus,
		output dev_data_out, dev_data_oe, transfer_ack_or_wait, ack_oe
	);
endinterface : hrp_bus_if

`default_nettype wire

// ---- hw/hrp_device.sv ----
// hrp_device: register port of the coprocessor, with pass-through to the byte-wide peripheral.
// Assumes host pins are asynchronous; register contents live in user logic behind reg_*.
`timescale 1ns/100ps
`default_nettype none

module hrp_device (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// static configuration
	input wire hrp_pkg::hrp_style_t bus_style,
	// host pins
	hrp_bus_if.dev_end bus,
	// register file side
	output logic [hrp_pkg::ADDR_W-1:0] reg_addr,
	output logic [hrp_pkg::DATA_W-1:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [hrp_pkg::DATA_W-1:0] reg_rdata,
	// peripheral pins
	output logic periph_chip_select_n,
	output logic periph_write_strobe,
	output logic periph_output_enable,
	output logic [hrp_pkg::DATA_W-1:0] periph_data_out,
	output logic periph_data_oe,
	input wire logic [hrp_pkg::DATA_W-1:0] periph_data_in
);
	logic [1:0] rst_sync_q;
	logic core_rst_n;
	hrp_pkg::hrp_dev_reg_t r_q;
	hrp_pkg::hrp_dev_reg_t r_d;
	logic [hrp_pkg::DATA_W-1:0] pt_cap_q;
	logic [hrp_pkg::NUM_SYNC-1:0] pins;
	logic split;
	logic sel_any;
	logic strobe_on;
	logic want_rd;
	logic raw_req;

	// reset asserts at once, releases on a rising edge
	always_ff @(posedge core_clk or negedge rst_n) begin // R17
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign core_rst_n = rst_sync_q[1];

	assign pins[hrp_pkg::SYN_SEL] = bus.host_select_n;
	assign pins[hrp_pkg::SYN_PASS] = bus.periph_pass_select_n;
	assign pins[hrp_pkg::SYN_DS] = bus.data_or_read_strobe_n;
	assign pins[hrp_pkg::SYN_RW] = bus.rw_or_write_strobe_n;

	assign split = (bus_style == hrp_pkg::STYLE_SPLIT); // R18
	assign sel_any = !r_q.filt[hrp_pkg::SYN_SEL] || !r_q.filt[hrp_pkg::SYN_PASS];
	// split style: either strobe low; strobe/rw style: data strobe low
	assign strobe_on = split ? (!r_q.filt[hrp_pkg::SYN_DS] || !r_q.filt[hrp_pkg::SYN_RW])
		: !r_q.filt[hrp_pkg::SYN_DS];
	assign want_rd = split ? !r_q.filt[hrp_pkg::SYN_DS] : r_q.filt[hrp_pkg::SYN_RW];
	// raw pin request pulls ready low without waiting for the synchronisers
	assign raw_req = (!bus.host_select_n || !bus.periph_pass_select_n)
		&& (!bus.data_or_read_strobe_n || !bus.rw_or_write_strobe_n);

	always_comb begin
		r_d = r_q;
		for (int i = 0; i < hrp_pkg::NUM_SYNC; i++) begin
			r_d.sync[i] = {r_q.sync[i][1:0], pins[i]}; // R1
			// a change counts once stages two and three agree
			if (r_q.sync[i][1] == r_q.sync[i][2]) begin
				r_d.filt[i] = r_q.sync[i][2];
			end
		end
		unique case (r_q.st)
			hrp_pkg::DEV_IDLE: begin
				// waits for the first edge at which the strobe is seen low
				if (sel_any && strobe_on) begin // R3 R2
					r_d.addr = bus.addr; // R5
					r_d.wr = !want_rd;
					r_d.pt = !r_q.filt[hrp_pkg::SYN_PASS];
					r_d.wdata = bus.data_bus; // R7 R9
					if (!r_q.filt[hrp_pkg::SYN_PASS]) begin
						r_d.st = want_rd ? hrp_pkg::DEV_PT_RD : hrp_pkg::DEV_PT_WR;
					end else begin
						r_d.st = want_rd ? hrp_pkg::DEV_REG_RD : hrp_pkg::DEV_REG_WR;
					end
				end
			end
			hrp_pkg::DEV_REG_WR: begin
				r_d.st = hrp_pkg::DEV_ACK; // R7
			end
			hrp_pkg::DEV_REG_RD: begin
				r_d.rdata = reg_rdata;
				r_d.st = hrp_pkg::DEV_ACK; // R6 R8
			end
			hrp_pkg::DEV_PT_RD: begin
				r_d.rdata = pt_cap_q; // R15
				r_d.st = hrp_pkg::DEV_ACK;
			end
			hrp_pkg::DEV_PT_WR: begin
				r_d.st = hrp_pkg::DEV_ACK; // R16
			end
			hrp_pkg::DEV_ACK: begin
				// ends only when the strobe release has been seen
				if (!strobe_on) begin // R4 R10 R11
					r_d.st = hrp_pkg::DEV_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			r_q.sync <= '1;
			r_q.filt <= '1;
			r_q.st <= hrp_pkg::DEV_IDLE;
			r_q.wr <= 1'b0;
			r_q.pt <= 1'b0;
			r_q.addr <= '0;
			r_q.wdata <= hrp_pkg::DATA_RST;
			r_q.rdata <= hrp_pkg::DATA_RST;
		end else begin
			r_q <= r_d;
		end
	end

	// peripheral byte is sampled mid-cycle while its select is driven
	always_ff @(negedge core_clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			pt_cap_q <= hrp_pkg::DATA_RST;
		end else if (r_q.st == hrp_pkg::DEV_PT_RD) begin
			pt_cap_q <= periph_data_in; // R15
		end
	end

	// host side outputs
	always_comb begin
		if (split) begin
			// ready low while busy, high once the data is done
			bus.ack_oe = raw_req || (r_q.st != hrp_pkg::DEV_IDLE); // R8 R9 R11
			bus.transfer_ack_or_wait = (r_q.st == hrp_pkg::DEV_ACK); // R8 R9
		end else begin
			bus.ack_oe = (r_q.st == hrp_pkg::DEV_ACK); // R6 R7 R10
			bus.transfer_ack_or_wait = 1'b0;
		end
	end
	assign bus.dev_data_oe = (r_q.st == hrp_pkg::DEV_ACK) && !r_q.wr; // R6 R8 R10
	assign bus.dev_data_out = r_q.rdata;

	// register file side
	assign reg_addr = r_q.addr;
	assign reg_wdata = r_q.wdata;
	assign reg_wr = (r_q.st == hrp_pkg::DEV_REG_WR);
	assign reg_rd = (r_q.st == hrp_pkg::DEV_REG_RD);

	// peripheral side
	assign periph_chip_select_n = !((r_q.st == hrp_pkg::DEV_PT_RD)
		|| (r_q.st == hrp_pkg::DEV_PT_WR)); // R14 R16
	assign periph_write_strobe = (r_q.st == hrp_pkg::DEV_PT_RD); // R14
	assign periph_output_enable = (r_q.st == hrp_pkg::DEV_PT_WR); // R16
	assign periph_data_out = r_q.wdata;
	assign periph_data_oe = (r_q.st == hrp_pkg::DEV_PT_WR); // R16 R19

endmodule : hrp_device

`default_nettype wire

// ---- hw/hrp_host.sv ----
// hrp_host: bus master end that runs one register or pass-through access per request.
// Assumes the device end shares core_clk; the ack wire reads high when undriven.
`timescale 1ns/100ps
`default_nettype none

module hrp_host (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// static configuration
	input wire hrp_pkg::hrp_style_t bus_style,
	// host pins
	hrp_bus_if.host_end bus,
	// request side
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_periph,
	input wire logic [hrp_pkg::ADDR_W-1:0] req_addr,
	input wire logic [hrp_pkg::DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [hrp_pkg::DATA_W-1:0] rsp_rdata
);
	hrp_pkg::hrp_hst_reg_t r_q;
	hrp_pkg::hrp_hst_reg_t r_d;
	logic split;
	logic active;
	logic strobing;
	logic done;

	assign split = (bus_style == hrp_pkg::STYLE_SPLIT);
	// split style ends on ready high, strobe/rw style on ack low
	assign done = split ? bus.ack_level : !bus.ack_level;

	always_comb begin
		r_d = r_q;
		r_d.rsp = 1'b0;
		unique case (r_q.st)
			hrp_pkg::HST_RST: begin
				r_d.cnt = r_q.cnt + 3'h1;
				if (r_q.cnt == hrp_pkg::RST_MIN_CLKS - 3'h1) begin // R17
					r_d.st = hrp_pkg::HST_IDLE;
				end
			end
			hrp_pkg::HST_IDLE: begin
				if (req_valid) begin
					r_d.wr = req_write;
					r_d.pt = req_periph;
					r_d.addr = req_addr;
					r_d.wdata = req_wdata;
					r_d.st = hrp_pkg::HST_SETUP;
				end
			end
			hrp_pkg::HST_SETUP: begin
				r_d.st = hrp_pkg::HST_STROBE; // R5
			end
			hrp_pkg::HST_STROBE: begin
				if (done) begin
					r_d.rdata = r_q.wr ? r_q.rdata : bus.data_bus;
					r_d.rsp = 1'b1;
					r_d.cnt = 3'h0;
					r_d.st = hrp_pkg::HST_HOLD;
				end
			end
			hrp_pkg::HST_HOLD: begin
				// strobe high long enough for the device to see the release
				r_d.cnt = r_q.cnt + 3'h1;
				if (r_q.cnt == hrp_pkg::HOST_GAP_CLKS - 3'h1) begin // R4
					r_d.st = hrp_pkg::HST_IDLE;
				end
			end
			default: begin
				r_d.st = hrp_pkg::HST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q.st <= hrp_pkg::HST_RST;
			r_q.cnt <= 3'h0;
			r_q.wr <= 1'b0;
			r_q.pt <= 1'b0;
			r_q.addr <= '0;
			r_q.wdata <= hrp_pkg::DATA_RST;
			r_q.rdata <= hrp_pkg::DATA_RST;
			r_q.rsp <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// select, address, rw and write data stay until after the strobe is high
	assign active = (r_q.st == hrp_pkg::HST_SETUP) || (r_q.st == hrp_pkg::HST_STROBE)
		|| (r_q.st == hrp_pkg::HST_HOLD); // R12 R13
	assign strobing = (r_q.st == hrp_pkg::HST_STROBE);

	assign bus.host_select_n = !(active && !r_q.pt); // R12
	assign bus.periph_pass_select_n = !(active && r_q.pt); // R12
	assign bus.addr = r_q.addr; // R12
	assign bus.host_data_out = r_q.wdata;
	assign bus.host_data_oe = active && r_q.wr; // R13
	always_comb begin
		if (split) begin
			bus.data_or_read_strobe_n = !(strobing && !r_q.wr);
			bus.rw_or_write_strobe_n = !(strobing && r_q.wr);
		end else begin
			bus.data_or_read_strobe_n = !strobing;
			bus.rw_or_write_strobe_n = !(active && r_q.wr); // R12
		end
	end

	assign req_ready = (r_q.st == hrp_pkg::HST_IDLE);
	assign rsp_valid = r_q.rsp;
	assign rsp_rdata = r_q.rdata;

endmodule : hrp_host

`default_nettype wire

// ---- testbench/hrp_chk.sv ----
// hrp_chk: timing checks on the host pins between host end and device end.
// Assumes one clock and an active-low reset shared by both ends.
`timescale 1ns/100ps
`default_nettype none

module hrp_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// host pins
	input wire logic host_select_n,
	input wire logic periph_pass_select_n,
	input wire logic data_or_read_strobe_n,
	input wire logic rw_or_write_strobe_n,
	input wire logic [hrp_pkg::ADDR_W-1:0] addr,
	input wire logic [hrp_pkg::DATA_W-1:0] host_data_out,
	input wire logic dev_data_oe,
	input wire logic ack_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic rd_go = !(host_select_n && periph_pass_select_n) && rw_or_write_strobe_n;

	rd_sync_a:
		assert property ($fell(data_or_read_strobe_n) && rd_go |-> !dev_data_oe [*3])
			else $error("read data before strobe synchronised");
	rd_data_a:
		assert property ($fell(data_or_read_strobe_n) && rd_go |-> ##[2:10] dev_data_oe)
			else $error("read data never driven");
	data_ack_a:
		assert property ($rose(dev_data_oe) |-> ack_oe)
			else $error("read data without ack");
	hold_end_a:
		assert property ($rose(data_or_read_strobe_n) && dev_data_oe |=> dev_data_oe)
			else $error("access ended before strobe release seen");
	bus_release_a:
		assert property ($rose(data_or_read_strobe_n) |-> ##[1:5] (!dev_data_oe && !ack_oe))
			else $error("bus or ack not released");
	wr_release_a:
		assert property ($rose(rw_or_write_strobe_n) && data_or_read_strobe_n
			|-> ##[1:5] !ack_oe) else $error("ready not released after write");
	addr_hold_a:
		assert property (!data_or_read_strobe_n && !$past(data_or_read_strobe_n)
			|-> $stable(addr) && $stable(rw_or_write_strobe_n) && $stable(host_select_n)
			&& $stable(periph_pass_select_n)) else $error("host changed access mid-strobe");
	wdata_hold_a:
		assert property (!rw_or_write_strobe_n && !$past(rw_or_write_strobe_n)
			|-> $stable(host_data_out) && $stable(addr)) else $error("write data changed");
	rst_idle_a:
		assert property ($rose(rst_n) |-> (host_select_n && periph_pass_select_n
			&& !dev_data_oe) [*4]) else $error("activity right after reset");
endmodule : hrp_chk

`default_nettype wire

// ---- testbench/tb_async_host_register_port.sv ----
// tb_async_host_register_port: host end and device end joined, register file and peripheral here.
// Assumes package, interface, both ends and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module tb_async_host_register_port;
	localparam logic [7:0] PERIPH_BYTE = 8'hA5;
	int n_mismatch = 0;
	int total_checks = 0;
	int wr_cnt = 0;
	int pt_wr_cnt = 0;
	int pt_rd_cnt = 0;
	int rd_cnt = 0;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	hrp_pkg::hrp_style_t style = hrp_pkg::STYLE_STROBE_RW;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic req_periph = 1'b0;
	logic [4:0] req_addr = 5'h00;
	logic [7:0] req_wdata = 8'h00;
	logic req_ready, rsp_valid, reg_wr, reg_rd, periph_chip_select_n;
	logic periph_write_strobe, periph_output_enable, periph_data_oe;
	logic [4:0] reg_addr;
	logic [7:0] rsp_rdata, reg_wdata, periph_data_out, pt_wdata;
	logic [7:0] regs [32];
	wire logic [7:0] reg_rdata = regs[reg_addr];
	// peripheral drives only while selected and strobed, else a changed pattern
	wire logic [7:0] periph_data_in = (!periph_chip_select_n && periph_write_strobe) ?
		PERIPH_BYTE : ~PERIPH_BYTE;

	initial forever #4 core_clk = ~core_clk;

	hrp_bus_if hrp_bus_if_inst (.core_clk);
	hrp_host hrp_host_inst (.core_clk, .rst_n, .bus_style(style), .bus(hrp_bus_if_inst),
		.req_valid, .req_write, .req_periph, .req_addr, .req_wdata, .req_ready, .rsp_valid,
		.rsp_rdata);
	hrp_device hrp_device_inst (.core_clk, .rst_n, .bus_style(style), .bus(hrp_bus_if_inst),
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .periph_chip_select_n,
		.periph_write_strobe, .periph_output_enable, .periph_data_out, .periph_data_oe,
		.periph_data_in);
	hrp_chk hrp_chk_inst (.core_clk, .rst_n,
		.host_select_n(hrp_bus_if_inst.host_select_n),
		.periph_pass_select_n(hrp_bus_if_inst.periph_pass_select_n),
		.data_or_read_strobe_n(hrp_bus_if_inst.data_or_read_strobe_n),
		.rw_or_write_strobe_n(hrp_bus_if_inst.rw_or_write_strobe_n),
		.addr(hrp_bus_if_inst.addr), .host_data_out(hrp_bus_if_inst.host_data_out),
		.dev_data_oe(hrp_bus_if_inst.dev_data_oe), .ack_oe(hrp_bus_if_inst.ack_oe));

	always @(posedge core_clk) begin
		if (reg_wr) begin
			regs[reg_addr] <= reg_wdata;
			wr_cnt++;
		end
		if (reg_rd) begin
			rd_cnt++;
		end
		if (periph_write_strobe) begin
			pt_rd_cnt++;
			`CHK(periph_chip_select_n, 1'b0)
		end
		if (periph_data_oe) begin
			pt_wr_cnt++;
			pt_wdata = periph_data_out;
			`CHK({periph_chip_select_n, periph_output_enable}, 2'b01)
		end
	end

	task automatic do_reset(input hrp_pkg::hrp_style_t s);
		@(negedge core_clk);
		rst_n = 1'b0;
		style = s;
		repeat (5) @(negedge core_clk);
		rst_n = 1'b1;
	endtask : do_reset

	task automatic access(input logic w, input logic p, input logic [4:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		req_valid = 1'b1;
		req_write = w;
		req_periph = p;
		req_addr = a;
		req_wdata = d;
		@(negedge core_clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 30) begin
			@(negedge core_clk);
			n++;
		end
		`CHK(rsp_valid, 1'b1)
	endtask : access

	task automatic reg_rw(input logic [4:0] a, input logic [7:0] d);
		int c;
		int r;
		c = wr_cnt;
		r = rd_cnt;
		access(1'b1, 1'b0, a, d);
		`CHK(wr_cnt, c + 1)
		`CHK(regs[a], d)
		`CHK(rd_cnt, r)
		access(1'b0, 1'b0, a, 8'h00);
		`CHK(rsp_rdata, d)
		`CHK(rd_cnt, r + 1)
		`CHK(wr_cnt, c + 1)
	endtask : reg_rw

	task automatic pt_read();
		int c;
		int w;
		c = pt_rd_cnt;
		w = pt_wr_cnt;
		access(1'b0, 1'b1, 5'h03, 8'h00);
		`CHK(rsp_rdata, PERIPH_BYTE)
		`CHK(pt_rd_cnt, c + 1)
		`CHK(pt_wr_cnt, w)
	endtask : pt_read

	task automatic pt_write(input logic [7:0] d);
		int c;
		c = pt_wr_cnt;
		access(1'b1, 1'b1, 5'h04, d);
		`CHK(pt_wr_cnt, c + 1)
		`CHK(pt_wdata, d)
	endtask : pt_write

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	initial begin
		for (int i = 0; i < 2; i++) begin
			do_reset(i ? hrp_pkg::STYLE_SPLIT : hrp_pkg::STYLE_STROBE_RW);
			reg_rw(5'h00, 8'h5A);
			reg_rw(5'h1F, 8'hC3);
			pt_read();
			pt_write(8'h3C);
			reg_rw(5'h0A, 8'h96);
		end
		print_verdict();
	end

	// guards against a hang in any handshake
	initial begin
		#20000;
		n_mismatch++;
		print_verdict();
	end
endmodule : tb_async_host_register_port

`default_nettype wire
